/* src/hfdb_defs.svh */
// shared constants of the firmware download boot block
`ifndef HFDB_DEFS_SVH
`define HFDB_DEFS_SVH
`define HFDB_PKT_CMD 8'h01
`define HFDB_PKT_EVT 8'h04
`define HFDB_EVT_DONE 8'h0e
`define HFDB_EVT_PLEN 8'h04
`define HFDB_NCMD 8'h01
`define HFDB_ST_OK 8'h00
`define HFDB_ST_BAD 8'h12
`define HFDB_WR_LO 8'h4c
`define HFDB_WR_HI 8'hfc
`define HFDB_RST_LO 8'h03
`define HFDB_RST_HI 8'h0c
`define HFDB_ADDR_LEN 8'h04
`define HFDB_ADDR_LAST 2'h3
`define HFDB_RESP_LAST 3'h6
`define HFDB_ACK_MS 200
`define HFDB_CLK_MHZ 250
`define HFDB_KHZ_PER_MHZ 1000
`define HFDB_RST_LINE 40'h80_2188_1a02
`define HFDB_RST_LAST 6'h27
`define HFDB_MIN_BIT 16'h0004
`define HFDB_DEF_DIV 16'h087a
`define HFDB_NSEC 4
`define HFDB_SS_BASE 32'h0050_0000
`define HFDB_SS_LEN 32'h0000_2000
`define HFDB_VOL_BASE 32'h0050_0400
`define HFDB_VOL_LEN 32'h0000_1000
`define HFDB_APP1_BASE 32'h0050_1400
`define HFDB_APP2_BASE 32'h0052_0a00
`define HFDB_APP_LEN 32'h0001_f600
`define HFDB_SECTOR 32'h0000_0200
`endif

/* src/hfdb_pkg.sv */
// types of the firmware download boot block
`default_nettype none
package hfdb_pkg;
	typedef enum logic [1:0] {M_BOOT, M_RECOV, M_READY, M_AUTO} hfdb_mode_t;
	typedef enum logic [2:0] {
		P_TYPE, P_OPLO, P_OPHI, P_LEN, P_ADDR, P_DATA, P_SKIP, P_RESP
	} hfdb_parse_t;
	typedef enum logic [1:0] {B_IDLE, B_LOW, B_CHK, B_LOCK} hfdb_baud_t;
endpackage : hfdb_pkg
`default_nettype wire

/* src/hfdb_baud_if.sv */
// carrier between the command parser and the baud detector
`default_nettype none
interface hfdb_baud_if #(
	parameter int W = 16
);
	logic arm;
	logic rx;
	logic locked;
	logic [W-1:0] period;
	modport det (input arm, input rx, output locked, output period);
	modport host (output arm, output rx, input locked, input period);
endinterface : hfdb_baud_if
`default_nettype wire

/* src/hfdb_baud.sv */
// receive-line baud detector matching the reset command bit pattern
`default_nettype none
`include "hfdb_defs.svh"
module hfdb_baud #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// parser side
	hfdb_baud_if.det bif
);
	localparam logic [39:0] PAT = `HFDB_RST_LINE;
	hfdb_pkg::hfdb_baud_t state;
	logic [W-1:0] cnt;
	logic [W-1:0] period;
	logic [5:0] k;

	if (W < 8) begin : g_bad_w
		$error("baud counter too narrow");
	end

	// start bit of the first byte is followed by a one, so its width is one bit time
	always_ff @(posedge clock_in) begin
		if (srst_in || !bif.arm) begin
			state <= hfdb_pkg::B_IDLE;
			cnt <= '0;
			period <= '0;
			k <= '0;
		end else begin
			unique case (state)
			hfdb_pkg::B_IDLE: begin
				if (!bif.rx) begin
					state <= hfdb_pkg::B_LOW;
					cnt <= W'(1);
				end
			end
			hfdb_pkg::B_LOW: begin
				if (bif.rx) begin
					if (cnt < W'(`HFDB_MIN_BIT)) begin
						state <= hfdb_pkg::B_IDLE;
					end else begin
						period <= cnt;
						cnt <= cnt >> 1;
						k <= 6'h01;
						state <= hfdb_pkg::B_CHK;
					end
				end else if (&cnt) begin
					state <= hfdb_pkg::B_IDLE;
				end else begin
					cnt <= cnt + 1'h1;
				end
			end
			hfdb_pkg::B_CHK: begin
				// no gap allowed between the four bytes; a gap just restarts the hunt
				if (cnt != '0) begin
					cnt <= cnt - 1'h1;
				end else if (bif.rx != PAT[k]) begin // RULE_12
					state <= hfdb_pkg::B_IDLE;
				end else if (k == `HFDB_RST_LAST) begin
					state <= hfdb_pkg::B_LOCK;
				end else begin
					k <= k + 6'h01;
					cnt <= period - 1'h1;
				end
			end
			hfdb_pkg::B_LOCK: begin
			end
			endcase
		end
	end

	assign bif.locked = (state == hfdb_pkg::B_LOCK);
	assign bif.period = period;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in);

	mismatch_drop_a: // RULE_12
	assert property ((state == hfdb_pkg::B_CHK && cnt == '0 && bif.rx != PAT[k])
		|=> state == hfdb_pkg::B_IDLE)
		else $error("pattern mismatch did not restart the hunt");

	lock_hold_a: // RULE_12
	assert property ((state == hfdb_pkg::B_LOCK && bif.arm)
		|=> bif.locked && $stable(period))
		else $error("lock or period lost while armed");
endmodule : hfdb_baud
`default_nettype wire

/* src/hfdb_boot.sv */
// command parser, boot mode strap and memory write path of the download block
`default_nettype none
`include "hfdb_defs.svh"
// Contract
// RULE_01: command record is two-byte opcode, length byte, then that many payload bytes
// RULE_02: host prefixes each command with packet type byte 01
// RULE_03: write length is four plus N; four address bytes, then N stored bytes
// RULE_04: each write is answered by the seven-byte completion event within 200 ms
// RULE_05: hex records start with a colon and end in carriage return, line feed
// RULE_06: hex record holds length byte, 16-bit address, type byte, then payload
// RULE_07: hex type 00 is data; address field gives low 16 address bits
// RULE_08: hex type 01 ends the image with empty payload and zero address
// RULE_09: hex type 04 payload gives upper 16 bits for later data records
// RULE_10: hex type 05 carries a four-byte 32-bit launch address
// RULE_11: clear-to-send low at reset selects recovery mode
// RULE_12: recovery finds baud from reset command line pattern and answers at it
// RULE_13: recovery may leave commands unanswered; host carries on regardless
// RULE_14: clear-to-send high: stored configuration gives ready mode, else autobaud
// RULE_15: host repeats any RAM download after every device reset
// RULE_16: flash programming goes through a loader stub started from RAM first
// RULE_17: static section at 0x500000, 0x2000 long; volatile store at 0x500400
// RULE_18: application partitions at 0x501400 and 0x520A00, each 0x1F600 long
// RULE_19: every section starts and ends on an erase sector boundary
// RULE_20: host waits for each acknowledgement or 200 ms timeout, else reports error
module hfdb_boot #(
	parameter int W = 16,
	parameter logic [W-1:0] DEF_DIV = W'(`HFDB_DEF_DIV),
	parameter int unsigned ACK_CYCLES = `HFDB_ACK_MS * `HFDB_CLK_MHZ * `HFDB_KHZ_PER_MHZ,
	parameter logic [31:0] SECTOR = `HFDB_SECTOR,
	parameter logic [31:0] SEC_BASE [`HFDB_NSEC] = '{
		`HFDB_SS_BASE, `HFDB_VOL_BASE, `HFDB_APP1_BASE, `HFDB_APP2_BASE},
	parameter logic [31:0] SEC_LEN [`HFDB_NSEC] = '{
		`HFDB_SS_LEN, `HFDB_VOL_LEN, `HFDB_APP_LEN, `HFDB_APP_LEN}
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// pins and boot straps
	input wire logic cts_in,
	input wire logic rxd_in,
	input wire logic cfg_present_in,
	// received command bytes
	input wire logic [7:0] rx_data_in,
	input wire logic rx_valid_in,
	// event bytes back to the host
	output var logic [7:0] tx_data_out,
	output var logic tx_valid_out,
	input wire logic tx_ready_in,
	// RAM write port
	output var logic mem_we_out,
	output var logic [31:0] mem_addr_out,
	output var logic [7:0] mem_data_out,
	output var logic [`HFDB_NSEC-1:0] mem_section_out,
	// boot status
	output var hfdb_pkg::hfdb_mode_t boot_mode_out,
	output var logic [W-1:0] baud_div_out,
	output var logic baud_locked_out
);
	hfdb_pkg::hfdb_parse_t pstate;
	hfdb_pkg::hfdb_parse_t next_pstate;
	hfdb_pkg::hfdb_parse_t fin_state;
	logic cts_s1;
	logic cts_s2;
	logic rx_s1;
	logic rx_s2;
	logic [15:0] opc;
	logic [7:0] rem;
	logic [1:0] aidx;
	logic [31:0] addr;
	logic bad;
	logic [2:0] ri;
	logic lock_pend;
	logic [31:0] ack_wait;
	logic [`HFDB_NSEC-1:0] hit;
	logic link_up;
	logic rx_take;
	logic is_wr;
	logic is_rst;
	logic answer;

	if (SECTOR == '0 || W < 8) begin : g_bad_cfg
		$error("sector size or divisor width unusable");
	end

	for (genvar i = 0; i < `HFDB_NSEC; i++) begin : g_sec
		if (SEC_BASE[i] % SECTOR != 0 || SEC_LEN[i] % SECTOR != 0) begin : g_align
			$error("section not on an erase sector boundary"); // RULE_19
		end
		// placements are parameter defaults only; an instance may override them
		assign hit[i] = addr >= SEC_BASE[i] && (addr - SEC_BASE[i]) < SEC_LEN[i]; // RULE_17 RULE_18
	end

	// pins come from outside the clock domain; no reset so the strap is valid at release
	always_ff @(posedge clock_in) begin
		cts_s1 <= cts_in;
		cts_s2 <= cts_s1;
		rx_s1 <= rxd_in;
		rx_s2 <= rx_s1;
	end

	hfdb_baud_if #(.W(W)) bif ();
	assign bif.arm = boot_mode_out == hfdb_pkg::M_RECOV || boot_mode_out == hfdb_pkg::M_AUTO;
	assign bif.rx = rx_s2;

	hfdb_baud #(.W(W)) u_baud (
		.clock_in(clock_in),
		.srst_in(srst_in),
		.bif(bif.det)
	);

	assign link_up = boot_mode_out == hfdb_pkg::M_READY || baud_locked_out;
	assign rx_take = rx_valid_in && link_up && pstate != hfdb_pkg::P_RESP;
	assign is_wr = opc == {`HFDB_WR_HI, `HFDB_WR_LO};
	assign is_rst = opc == {`HFDB_RST_HI, `HFDB_RST_LO};
	assign answer = boot_mode_out != hfdb_pkg::M_RECOV || is_wr || is_rst; // RULE_13
	assign fin_state = answer ? hfdb_pkg::P_RESP : hfdb_pkg::P_TYPE;

	// strap is read once, in the first cycle after reset release
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			boot_mode_out <= hfdb_pkg::M_BOOT;
		end else if (boot_mode_out == hfdb_pkg::M_BOOT) begin
			if (!cts_s2) begin
				boot_mode_out <= hfdb_pkg::M_RECOV; // RULE_11
			end else if (cfg_present_in) begin
				boot_mode_out <= hfdb_pkg::M_READY; // RULE_14
			end else begin
				boot_mode_out <= hfdb_pkg::M_AUTO; // RULE_14
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			baud_locked_out <= 1'h0;
			lock_pend <= 1'h0;
			baud_div_out <= DEF_DIV;
		end else begin
			baud_locked_out <= bif.locked;
			if (bif.locked && !baud_locked_out) begin
				lock_pend <= 1'h1; // RULE_12
			end else if (pstate == hfdb_pkg::P_TYPE) begin
				lock_pend <= 1'h0;
			end
			baud_div_out <= bif.locked ? bif.period : DEF_DIV;
		end
	end

	always_comb begin
		next_pstate = pstate;
		unique case (pstate)
		hfdb_pkg::P_TYPE: begin
			if (lock_pend) begin
				next_pstate = hfdb_pkg::P_RESP;
			end else if (rx_take && rx_data_in == `HFDB_PKT_CMD) begin // RULE_02
				next_pstate = hfdb_pkg::P_OPLO;
			end
		end
		hfdb_pkg::P_OPLO: begin
			if (rx_take) begin
				next_pstate = hfdb_pkg::P_OPHI;
			end
		end
		hfdb_pkg::P_OPHI: begin
			if (rx_take) begin
				next_pstate = hfdb_pkg::P_LEN;
			end
		end
		hfdb_pkg::P_LEN: begin
			if (rx_take) begin
				if (is_wr && rx_data_in >= `HFDB_ADDR_LEN) begin // RULE_03
					next_pstate = hfdb_pkg::P_ADDR;
				end else if (rx_data_in == '0) begin
					next_pstate = fin_state;
				end else begin
					next_pstate = hfdb_pkg::P_SKIP; // RULE_01
				end
			end
		end
		hfdb_pkg::P_ADDR: begin
			if (rx_take && aidx == `HFDB_ADDR_LAST) begin
				next_pstate = rem == '0 ? fin_state : hfdb_pkg::P_DATA;
			end
		end
		hfdb_pkg::P_DATA, hfdb_pkg::P_SKIP: begin
			if (rx_take && rem == 8'h01) begin
				next_pstate = fin_state;
			end
		end
		hfdb_pkg::P_RESP: begin
			if (tx_valid_out && tx_ready_in && ri == `HFDB_RESP_LAST) begin
				next_pstate = hfdb_pkg::P_TYPE;
			end
		end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			pstate <= hfdb_pkg::P_TYPE;
		end else begin
			pstate <= next_pstate;
		end
	end

	// command fields; address bytes arrive least significant first
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			opc <= '0;
			rem <= '0;
			aidx <= '0;
			addr <= '0;
			bad <= 1'h0;
		end else if (pstate == hfdb_pkg::P_TYPE && lock_pend) begin
			opc <= {`HFDB_RST_HI, `HFDB_RST_LO}; // RULE_12
			bad <= 1'h0;
		end else if (rx_take) begin
			unique case (pstate)
			hfdb_pkg::P_OPLO: opc[7:0] <= rx_data_in; // RULE_01
			hfdb_pkg::P_OPHI: opc[15:8] <= rx_data_in;
			hfdb_pkg::P_LEN: begin
				aidx <= '0;
				if (is_wr && rx_data_in >= `HFDB_ADDR_LEN) begin
					rem <= rx_data_in - `HFDB_ADDR_LEN; // RULE_03
					bad <= 1'h0;
				end else begin
					rem <= rx_data_in;
					bad <= is_wr;
				end
			end
			hfdb_pkg::P_ADDR: begin
				addr <= {rx_data_in, addr[31:8]}; // RULE_03
				aidx <= aidx + 2'h1;
			end
			hfdb_pkg::P_DATA: begin
				addr <= addr + 32'h1;
				rem <= rem - 8'h01;
			end
			hfdb_pkg::P_SKIP: rem <= rem - 8'h01;
			hfdb_pkg::P_TYPE, hfdb_pkg::P_RESP: begin
			end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			mem_we_out <= 1'h0;
			mem_addr_out <= '0;
			mem_data_out <= '0;
			mem_section_out <= '0;
		end else begin
			mem_we_out <= pstate == hfdb_pkg::P_DATA && rx_take;
			if (pstate == hfdb_pkg::P_DATA && rx_take) begin
				mem_addr_out <= addr; // RULE_03
				mem_data_out <= rx_data_in;
				mem_section_out <= hit;
			end
		end
	end

	function automatic logic [7:0] resp_byte(input logic [2:0] i, input logic [15:0] op,
		input logic err);
		unique case (i)
		3'h0: resp_byte = `HFDB_PKT_EVT;
		3'h1: resp_byte = `HFDB_EVT_DONE;
		3'h2: resp_byte = `HFDB_EVT_PLEN;
		3'h3: resp_byte = `HFDB_NCMD;
		3'h4: resp_byte = op[7:0];
		3'h5: resp_byte = op[15:8];
		default: resp_byte = err ? `HFDB_ST_BAD : `HFDB_ST_OK;
		endcase
	endfunction : resp_byte

	// response goes out as soon as the command ends; only the host's ready can delay it
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			tx_valid_out <= 1'h0;
			tx_data_out <= '0;
			ri <= '0;
		end else if (pstate != hfdb_pkg::P_RESP && next_pstate == hfdb_pkg::P_RESP) begin
			tx_valid_out <= 1'h1; // RULE_04
			tx_data_out <= `HFDB_PKT_EVT;
			ri <= '0;
		end else if (tx_valid_out && tx_ready_in) begin
			if (ri == `HFDB_RESP_LAST) begin
				tx_valid_out <= 1'h0;
			end else begin
				ri <= ri + 3'h1;
				tx_data_out <= resp_byte(ri + 3'h1, opc, bad); // RULE_04
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in || pstate != hfdb_pkg::P_RESP) begin
			ack_wait <= '0;
		end else begin
			ack_wait <= ack_wait + 32'h1;
		end
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in);

	strap_recov_a: // RULE_11
	assert property ((!srst_in && boot_mode_out == hfdb_pkg::M_BOOT && !cts_s2)
		|=> boot_mode_out == hfdb_pkg::M_RECOV)
		else $error("low strap did not select recovery");

	strap_ready_a: // RULE_14
	assert property ((!srst_in && boot_mode_out == hfdb_pkg::M_BOOT && cts_s2)
		|=> boot_mode_out == ($past(cfg_present_in) ? hfdb_pkg::M_READY : hfdb_pkg::M_AUTO))
		else $error("high strap chose the wrong mode");

	type_gate_a: // RULE_02
	assert property ((pstate == hfdb_pkg::P_TYPE && !lock_pend && rx_take
		&& rx_data_in != `HFDB_PKT_CMD) |=> pstate == hfdb_pkg::P_TYPE)
		else $error("non-command packet type was parsed");

	len_route_a: // RULE_01
	assert property ((pstate == hfdb_pkg::P_LEN && rx_take && !is_wr && rx_data_in != '0)
		|=> pstate == hfdb_pkg::P_SKIP && rem == $past(rx_data_in))
		else $error("payload length not followed");

	wr_store_a: // RULE_03
	assert property ((pstate == hfdb_pkg::P_DATA && rx_take)
		|=> mem_we_out && mem_data_out == $past(rx_data_in) && mem_addr_out == $past(addr))
		else $error("payload byte not stored at its address");

	ack_start_a: // RULE_04
	assert property ((pstate == hfdb_pkg::P_DATA && rx_take && rem == 8'h01)
		|=> ((tx_valid_out && tx_data_out == `HFDB_PKT_EVT)
		and (tx_ready_in [*4] |=> tx_data_out == `HFDB_WR_LO)))
		else $error("write acknowledgement malformed");

	ack_time_a: // RULE_04
	assert property (ack_wait < ACK_CYCLES)
		else $error("acknowledgement later than its deadline");

	recov_quiet_a: // RULE_13
	assert property ((boot_mode_out == hfdb_pkg::M_RECOV && pstate == hfdb_pkg::P_RESP)
		|-> is_wr || is_rst)
		else $error("recovery answered an unsupported command");

	reset_resp_a: // RULE_12
	assert property ($rose(baud_locked_out)
		|-> ##[1:4] (tx_valid_out && tx_data_out == `HFDB_PKT_EVT))
		else $error("no reset response after baud lock");

	sect_map_a: // RULE_18
	assert property ((mem_we_out && mem_addr_out >= SEC_BASE[2]
		&& (mem_addr_out - SEC_BASE[2]) < SEC_LEN[2]) |-> mem_section_out[2])
		else $error("first partition write not flagged");
endmodule : hfdb_boot
`default_nettype wire

/* tb/hfdb_host.sv */
// host-side model: frames commands, plays the reset line pattern, paces responses
`default_nettype none
module hfdb_host (
	// clock
	input wire logic clock_in,
	// response pacing
	input wire logic stall_in,
	// link toward the device
	output var logic [7:0] rx_data_out,
	output var logic rx_valid_out,
	output var logic tx_ready_out,
	output var logic rxd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] pace = 2'h0;
	initial begin
		rx_data_out = 8'h00;
		rx_valid_out = 1'b0;
		tx_ready_out = 1'b1;
		rxd_out = 1'b1;
	end
	// stalling accepts one byte in four, no kinder than a busy transmitter
	always @(posedge clock_in) begin
		pace <= pace + 2'h1;
		tx_ready_out <= !stall_in || (pace == 2'h3);
	end
	task automatic put_byte(input logic [7:0] b);
		@(posedge clock_in);
		rx_data_out <= b;
		rx_valid_out <= 1'b1;
	endtask : put_byte
	task automatic send_cmd(input logic [15:0] op, input logic [7:0] pl [16], input int n);
		put_byte(8'h01);
		put_byte(op[7:0]);
		put_byte(op[15:8]);
		put_byte(8'(n));
		for (int i = 0; i < n; i++) begin
			put_byte(pl[i]);
		end
		@(posedge clock_in);
		// released data shows no stale byte
		rx_data_out <= ~rx_data_out;
		rx_valid_out <= 1'b0;
	endtask : send_cmd
	// reset command 01 03 0c 00 as 8n1, lsb first, no gaps
	task automatic send_line(input int p);
		logic [7:0] fr [4] = '{8'h01, 8'h03, 8'h0c, 8'h00};
		for (int k = 0; k < 4; k++) begin
			for (int j = 0; j < 10; j++) begin
				@(posedge clock_in);
				rxd_out <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : fr[k][j - 1];
				repeat (p - 1) @(posedge clock_in);
			end
		end
	endtask : send_line
endmodule : hfdb_host
`default_nettype wire

/* tb/hci_firmware_download_boot_tb_top.sv */
// self-checking bench of the firmware download boot block
`default_nettype none
`include "hfdb_defs.svh"
module hci_firmware_download_boot_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic srst_in = 1'b1;
	logic cts_in = 1'b1;
	logic cfg_present_in = 1'b1;
	logic stall = 1'b0;
	logic rxd;
	logic [7:0] rx_data;
	logic rx_valid;
	logic tx_ready_in;
	logic [7:0] tx_data_out;
	logic tx_valid_out;
	logic mem_we_out;
	logic [31:0] mem_addr_out;
	logic [7:0] mem_data_out;
	logic [3:0] mem_section_out;
	hfdb_pkg::hfdb_mode_t boot_mode_out;
	logic [15:0] baud_div_out;
	logic baud_locked_out;
	int fail_count = 0;
	int samples_checked = 0;
	logic [7:0] rsp_q [$];
	logic [43:0] mem_q [$];
	logic [31:0] rng = 32'h2a46;
	logic [7:0] none [16];
	logic [7:0] hex_dat [16];
	logic [15:0] hex_upper = 16'h0000;
	logic [31:0] launch_addr = 32'h0000_0000;
	always #2 clock_in = ~clock_in;
	hfdb_host hfdb_host_i (.clock_in(clock_in), .stall_in(stall), .rx_data_out(rx_data),
		.rx_valid_out(rx_valid), .tx_ready_out(tx_ready_in), .rxd_out(rxd));
	hfdb_boot hfdb_boot_i (.clock_in(clock_in), .srst_in(srst_in), .cts_in(cts_in),
		.rxd_in(rxd), .cfg_present_in(cfg_present_in), .rx_data_in(rx_data),
		.rx_valid_in(rx_valid), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
		.tx_ready_in(tx_ready_in), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
		.mem_data_out(mem_data_out), .mem_section_out(mem_section_out),
		.boot_mode_out(boot_mode_out), .baud_div_out(baud_div_out),
		.baud_locked_out(baud_locked_out));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs
	function automatic logic [3:0] sec_of(input logic [31:0] a);
		logic [31:0] b [4] = '{`HFDB_SS_BASE, `HFDB_VOL_BASE, `HFDB_APP1_BASE, `HFDB_APP2_BASE};
		logic [31:0] l [4] = '{`HFDB_SS_LEN, `HFDB_VOL_LEN, `HFDB_APP_LEN, `HFDB_APP_LEN};
		sec_of = 4'h0;
		for (int i = 0; i < 4; i++) sec_of[i] = (a >= b[i]) && (a < b[i] + l[i]);
	endfunction : sec_of
	function automatic logic [7:0] hx_byte(input string s, input int p);
		return 8'(s.substr(p, p + 1).atohex());
	endfunction : hx_byte
	task automatic finish_test();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// monitor: each result takes the oldest note
	always @(posedge clock_in) begin
		if (tx_valid_out === 1'b1 && tx_ready_in === 1'b1) begin
			if (rsp_q.size() == 0) check("tx unasked", 64'h0, 64'h1);
			else check("tx byte", 64'(rsp_q.pop_front()), 64'(tx_data_out));
		end
		if (mem_we_out === 1'b1) begin
			if (mem_q.size() == 0) check("mem unasked", 64'h0, 64'h1);
			else check("mem write", 64'(mem_q.pop_front()),
				64'({mem_section_out, mem_addr_out, mem_data_out}));
		end
	end
	task automatic expect_rsp(input logic [15:0] op, input logic [7:0] st);
		rsp_q.push_back(`HFDB_PKT_EVT);
		rsp_q.push_back(`HFDB_EVT_DONE);
		rsp_q.push_back(`HFDB_EVT_PLEN);
		rsp_q.push_back(`HFDB_NCMD);
		rsp_q.push_back(op[7:0]);
		rsp_q.push_back(op[15:8]);
		rsp_q.push_back(st);
	endtask : expect_rsp
	// the host waits for the ack under a bound, far inside 200 ms
	task automatic drain();
		int i = 0;
		while (rsp_q.size() != 0 && i < 400) begin
			@(posedge clock_in);
			i++;
		end
		repeat (2) @(posedge clock_in);
		check("mem left", 64'h0, 64'(mem_q.size()));
		if (i >= 400) begin
			check("ack timeout", 64'h0, 64'h1);
			finish_test();
		end
	endtask : drain
	task automatic write_cmd(input logic [31:0] a, input int n, input logic [7:0] st,
		input bit hx = 1'b0);
		logic [7:0] pl [16];
		for (int i = 0; i < 4; i++) pl[i] = a[8*i +: 8];
		for (int i = 0; i < n; i++) begin
			rng = xs(rng);
			pl[4 + i] = hx ? hex_dat[i] : rng[7:0];
			mem_q.push_back({sec_of(a + 32'(i)), a + 32'(i), pl[4 + i]});
		end
		expect_rsp({`HFDB_WR_HI, `HFDB_WR_LO}, st);
		hfdb_host_i.send_cmd({`HFDB_WR_HI, `HFDB_WR_LO}, pl, 4 + n);
		drain();
	endtask : write_cmd
	// host loader: one ascii hex record; no checksum field is carried
	task automatic hex_load(input string s);
		logic [7:0] len;
		logic [15:0] ofs;
		logic [7:0] typ;
		int e;
		e = s.len();
		if (e < 11 || s[0] != 8'h3a || s[e - 2] != 8'h0d || s[e - 1] != 8'h0a) begin
			check("hex frame", 64'h0, 64'h1);
			return;
		end
		len = hx_byte(s, 1);
		ofs = {hx_byte(s, 3), hx_byte(s, 5)};
		typ = hx_byte(s, 7);
		for (int i = 0; i < 16 && i < int'(len); i++) hex_dat[i] = hx_byte(s, 9 + 2 * i);
		if (typ == 8'h00) begin
			write_cmd({hex_upper, ofs}, int'(len), `HFDB_ST_OK, 1'b1);
		end else if (typ == 8'h04) begin
			hex_upper = {hex_dat[0], hex_dat[1]};
		end else if (typ == 8'h05 && len == 8'h04 && ofs == 16'h0000) begin
			launch_addr = {hex_dat[0], hex_dat[1], hex_dat[2], hex_dat[3]};
		end else if (typ == 8'h01) begin
			check("hex end", 64'h0, 64'({len, ofs}));
		end
	endtask : hex_load
	task automatic do_reset(input logic cts, input logic cfg, input hfdb_pkg::hfdb_mode_t m);
		@(posedge clock_in);
		srst_in <= 1'b1;
		cts_in <= cts;
		cfg_present_in <= cfg;
		repeat (8) @(posedge clock_in);
		check("reset div", 64'(`HFDB_DEF_DIV), 64'(baud_div_out));
		srst_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		check("boot mode", 64'(m), 64'(boot_mode_out));
	endtask : do_reset
	initial begin
		logic [31:0] b [4] = '{`HFDB_SS_BASE, `HFDB_VOL_BASE, `HFDB_APP1_BASE, `HFDB_APP2_BASE};
		int i;
		do_reset(1'b1, 1'b1, hfdb_pkg::M_READY);
		for (int k = 0; k < 4; k++) begin
			rng = xs(rng);
			stall <= rng[0];
			// upper half from the section base, lower half the base plus a random byte offset
			write_cmd({b[k][31:16], b[k][15:0] + 16'(rng[15:8])}, 1 + k, `HFDB_ST_OK);
		end
		write_cmd(32'h0000_1000, -2, `HFDB_ST_BAD);
		hex_load(":020000040052\015\012");
		hex_load(":030a00005aa50f\015\012");
		hex_load(":0400000500501400\015\012");
		hex_load(":00000001\015\012");
		// payload of a command that is not a write is skipped, still answered
		expect_rsp(16'h1001, `HFDB_ST_OK);
		hfdb_host_i.send_cmd(16'h1001, hex_dat, 3);
		drain();
		hfdb_host_i.put_byte(8'h55);
		expect_rsp({`HFDB_RST_HI, `HFDB_RST_LO}, `HFDB_ST_OK);
		hfdb_host_i.send_cmd({`HFDB_RST_HI, `HFDB_RST_LO}, none, 0);
		drain();
		do_reset(1'b1, 1'b0, hfdb_pkg::M_AUTO);
		do_reset(1'b0, 1'b0, hfdb_pkg::M_RECOV);
		expect_rsp({`HFDB_RST_HI, `HFDB_RST_LO}, `HFDB_ST_OK);
		hfdb_host_i.send_line(8);
		i = 0;
		while (baud_locked_out !== 1'b1 && i < 600) begin
			@(posedge clock_in);
			i++;
		end
		check("baud lock", 64'h1, 64'(baud_locked_out));
		if (baud_locked_out !== 1'b1) finish_test();
		check("baud div", 64'h8, 64'(baud_div_out));
		drain();
		// stub load goes unanswered in recovery; the host carries on with writes
		hfdb_host_i.send_cmd(16'h1001, none, 0);
		write_cmd(launch_addr, 3, `HFDB_ST_OK);
		finish_test();
	end
endmodule : hci_firmware_download_boot_tb_top
`default_nettype wire
